// ==== crft_core.sv ====
`timescale 1ns/10ps
`include "crft_cfg.svh"

module crft_core
  import crft_pkg::*;
#(
  parameter int unsigned STORE_BUSY = `CRFT_STORE_BUSY
) (
  // clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,

  // fault sources
  input  wire logic        fault_i,
  input  wire logic        exc_active_i,

  // supervisor register writes
  input  wire logic        status_word_wr_i,
  input  wire logic [15:0] status_word_i,
  input  wire logic        vector_base_wr_i,
  input  wire logic [31:0] vector_base_i,
  input  wire logic        memctl_wr_i,
  input  wire logic [1:0]  memctl_i,

  // operation request
  input  wire logic        op_valid_i,
  input  crft_ea_e         op_src_ea_i,
  input  crft_ea_e         op_dst_ea_i,
  input  crft_size_e       op_size_i,
  input  wire logic        op_multi_move_i,
  input  wire logic        op_rmw_i,
  input  wire logic [31:0] op_src_addr_i,
  input  wire logic [31:0] op_dst_addr_i,
  input  wire logic [31:0] op_wdata_i,

  // operation answer
  output logic             op_ready_o,
  output logic             op_done_o,
  output logic             op_err_o,
  output logic [31:0]      op_rdata_o,
  output logic [7:0]       op_cycles_o,
  output logic [2:0]       op_reads_o,
  output logic [2:0]       op_writes_o,
  output logic [1:0]       op_stall_o,

  // internal core bus
  output logic             bus_req_o,
  output logic             bus_write_o,
  output logic [31:0]      bus_addr_o,
  output crft_size_e       bus_size_o,
  output logic [31:0]      bus_wdata_o,
  input  wire logic        bus_ack_i,
  input  wire logic        bus_err_i,
  input  wire logic [31:0] bus_rdata_i,

  // core state
  output logic             halted_o,
  output logic             running_o,
  output logic [15:0]      status_word_o,
  output logic [31:0]      vector_base_o,
  output logic [1:0]       memctl_o,
  output logic [31:0]      stack_ptr_o,
  output logic [31:0]      prog_ctr_o
);

  if (STORE_BUSY < 1 || STORE_BUSY > 3) begin : g_chk
    $error("STORE_BUSY must be 1 to 3");
  end

  //////////////////////////////////////////////////////////////////////////

  crft_state_e state;
  crft_state_e next_state;
  crft_state_e first_phase;
  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic        first_exec;
  logic [1:0]  busy;
  logic [1:0]  stall_cnt;
  logic        bus_last;

  // captured operation
  logic        q_rd;
  logic        q_wr;
  logic        q_copy;
  logic        q_multi;
  crft_size_e  q_size;
  logic [31:0] q_rd_addr;
  logic [31:0] q_wr_addr;
  logic [31:0] q_wdata;
  logic [7:0]  q_cycles;
  logic [2:0]  q_reads;
  logic [2:0]  q_writes;

  // request seen in idle, else the captured copy
  logic        in_idle;
  logic        take;
  logic        cur_rd;
  logic        cur_wr;
  logic        cur_copy;
  logic        cur_multi;
  crft_size_e  cur_size;
  logic [31:0] cur_rd_addr;
  logic [31:0] cur_wr_addr;
  logic [31:0] cur_wdata;

  logic        early;
  logic        halt_evt;
  logic        bus_busy_state;

  // piece of the operand for the next bus cycle
  logic [31:0] p_addr;
  crft_size_e  p_size;
  logic [1:0]  p_off;
  logic        p_last;
  logic [2:0]  w_shift;
  logic [31:0] w_val;

  logic [7:0]  t_cycles;
  logic [2:0]  t_reads;
  logic [2:0]  t_writes;

  //////////////////////////////////////////////////////////////////////////

  assign in_idle     = state == ST_IDLE;
  assign take        = in_idle && op_valid_i && op_ready_o;
  assign cur_rd      = in_idle ? (ea_is_mem(op_src_ea_i) || op_rmw_i) : q_rd;
  assign cur_wr      = in_idle ? (ea_is_mem(op_dst_ea_i) || op_rmw_i) : q_wr;
  assign cur_copy    = in_idle ? (ea_is_mem(op_src_ea_i) && !op_rmw_i)
                               : q_copy;
  assign cur_multi   = in_idle ? op_multi_move_i : q_multi;
  assign cur_size    = in_idle ? op_size_i : q_size;
  assign cur_rd_addr = in_idle ? (op_rmw_i ? op_dst_addr_i : op_src_addr_i)
                               : q_rd_addr;
  assign cur_wr_addr = in_idle ? op_dst_addr_i : q_wr_addr;
  assign cur_wdata   = in_idle ? op_wdata_i : q_wdata;

  assign first_phase = cur_rd ? ST_READ : (cur_wr ? ST_WRITE : ST_DONE);

  // faults count as double during exception processing or when no instruction has yet run
  assign early    = exc_active_i || !first_exec;
  assign bus_busy_state = state inside {ST_RST_SP, ST_RST_PC, ST_FETCH,
                                        ST_READ, ST_WRITE};
  assign halt_evt = state != ST_HALT &&
                    ((fault_i && early) ||
                     (bus_err_i && bus_req_o && early) ||
                     (state == ST_RST_PC && bus_ack_i &&
                      bus_rdata_i[0]));

  //////////////////////////////////////////////////////////////////////////

  crft_timing u_timing (
    .src_ea_i (op_src_ea_i),
    .dst_ea_i (op_dst_ea_i),
    .size_i   (op_size_i),
    .rmw_i    (op_rmw_i),
    .rd_lo_i  (cur_rd_addr[1:0]),
    .wr_lo_i  (op_dst_addr_i[1:0]),
    .cycles_o (t_cycles),
    .reads_o  (t_reads),
    .writes_o (t_writes)
  );

  crft_split u_split (
    .addr_i       ((next_state == ST_WRITE) ? cur_wr_addr : cur_rd_addr),
    .size_i       (cur_size),
    .idx_i        (next_idx),
    .piece_addr_o (p_addr),
    .piece_size_o (p_size),
    .piece_off_o  (p_off),
    .piece_last_o (p_last)
  );

  // big-endian: earlier pieces are the more significant bytes
  assign w_shift = 3'(size_bytes(cur_size) - {1'b0, p_off}
                      - size_bytes(p_size));
  assign w_val   = cur_copy ? next_acc : cur_wdata;

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_acc   = acc;
    unique case (state)
      ST_RST_SP: if (bus_ack_i) next_state = ST_RST_PC;
      ST_RST_PC: if (bus_ack_i) next_state = ST_FETCH;
      ST_FETCH:  if (bus_ack_i) next_state = ST_IDLE;
      ST_IDLE: if (take) begin
        next_idx = 2'h0;
        next_acc = 32'h0;
        if (cur_wr && !cur_multi && busy != 2'h0) begin
          next_state = ST_STALL;
        end else begin
          next_state = first_phase;
        end
      end
      ST_STALL: if (busy == 2'h0) next_state = first_phase;
      ST_READ: if (bus_err_i) begin
        next_state = ST_DONE;
      end else if (bus_ack_i) begin
        next_acc = (acc << {size_bytes(bus_size_o), 3'h0}) |
                   (bus_rdata_i & size_mask(bus_size_o));
        if (bus_last) begin
          next_idx   = 2'h0;
          next_state = cur_wr ? ST_WRITE : ST_DONE;
        end else begin
          next_idx = idx + 2'h1;
        end
      end
      ST_WRITE: if (bus_err_i) begin
        next_state = ST_DONE;
      end else if (bus_ack_i) begin
        if (bus_last) begin
          next_idx   = 2'h0;
          next_state = ST_DONE;
        end else begin
          next_idx = idx + 2'h1;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      ST_HALT: next_state = ST_HALT;
    endcase
    if (halt_evt) next_state = ST_HALT;
  end

  // reset abandons any operation; nothing of it is kept
  always_ff @(posedge ref_clk_i or posedge rst_i) begin : fsm
    if (rst_i) begin
      state <= ST_RST_SP;
      idx   <= 2'h0;
      acc   <= 32'h0;
    end else if (clk_en_i) begin
      state <= next_state;
      idx   <= next_idx;
      acc   <= next_acc;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk_i or posedge rst_i) begin : capture
    if (rst_i) begin
      q_rd      <= 1'b0;
      q_wr      <= 1'b0;
      q_copy    <= 1'b0;
      q_multi   <= 1'b0;
      q_size    <= SZ_LONG;
      q_rd_addr <= 32'h0;
      q_wr_addr <= 32'h0;
      q_wdata   <= 32'h0;
      q_cycles  <= 8'h0;
      q_reads   <= 3'h0;
      q_writes  <= 3'h0;
    end else if (clk_en_i && take) begin
      q_rd      <= cur_rd;
      q_wr      <= cur_wr;
      q_copy    <= cur_copy;
      q_multi   <= cur_multi;
      q_size    <= cur_size;
      q_rd_addr <= cur_rd_addr;
      q_wr_addr <= cur_wr_addr;
      q_wdata   <= cur_wdata;
      q_cycles  <= t_cycles;
      q_reads   <= t_reads;
      q_writes  <= t_writes;
    end
  end

  // store window; multi-register moves use their own resources
  always_ff @(posedge ref_clk_i or posedge rst_i) begin : store_busy
    if (rst_i) begin
      busy <= 2'h0;
    end else if (clk_en_i) begin
      if (state == ST_WRITE && bus_ack_i && bus_last && !q_multi) begin
        busy <= 2'(STORE_BUSY);
      end else if (busy != 2'h0) begin
        busy <= busy - 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin : stall_count
    if (rst_i) begin
      stall_cnt <= 2'h0;
    end else if (clk_en_i) begin
      if (take) begin
        stall_cnt <= 2'h0;
      end else if (state == ST_STALL) begin
        stall_cnt <= stall_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin : first_flag
    if (rst_i) begin
      first_exec <= 1'b0;
    end else if (clk_en_i && state == ST_DONE) begin
      first_exec <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk_i or posedge rst_i) begin : bus_drive
    if (rst_i) begin
      bus_req_o   <= 1'b0;
      bus_write_o <= 1'b0;
      bus_addr_o  <= 32'h0;
      bus_size_o  <= SZ_LONG;
      bus_wdata_o <= 32'h0;
      bus_last    <= 1'b1;
    end else if (clk_en_i) begin
      bus_req_o   <= next_state inside {ST_RST_SP, ST_RST_PC, ST_FETCH,
                                        ST_READ, ST_WRITE};
      bus_write_o <= next_state == ST_WRITE;
      bus_wdata_o <= 32'h0;
      bus_last    <= 1'b1;
      unique case (next_state)
        ST_RST_SP: begin
          bus_addr_o <= `CRFT_SP_VEC_ADDR;
          bus_size_o <= SZ_LONG;
        end
        ST_RST_PC: begin
          bus_addr_o <= `CRFT_PC_VEC_ADDR;
          bus_size_o <= SZ_LONG;
        end
        ST_FETCH: begin
          bus_addr_o <= (state == ST_RST_PC) ? bus_rdata_i
                                             : prog_ctr_o;
          bus_size_o <= SZ_WORD;
        end
        ST_READ, ST_WRITE: begin
          bus_addr_o  <= p_addr;
          bus_size_o  <= p_size;
          bus_last    <= p_last;
          bus_wdata_o <= (w_val >> {w_shift, 3'h0}) & size_mask(p_size);
        end
        default: begin
          bus_addr_o <= bus_addr_o;
          bus_size_o <= bus_size_o;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin : vectors
    if (rst_i) begin
      stack_ptr_o <= 32'h0;
      prog_ctr_o  <= 32'h0;
    end else if (clk_en_i && bus_ack_i && !bus_err_i) begin
      if (state == ST_RST_SP) stack_ptr_o <= bus_rdata_i;
      if (state == ST_RST_PC) prog_ctr_o  <= bus_rdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk_i or posedge rst_i) begin : supervisor
    if (rst_i) begin
      status_word_o <= `CRFT_SW_RESET;
      vector_base_o <= `CRFT_VBR_RESET;
      memctl_o      <= `CRFT_MEMCTL_RESET;
    end else if (clk_en_i) begin
      if (status_word_wr_i) status_word_o <= status_word_i;
      if (vector_base_wr_i) vector_base_o <= vector_base_i;
      if (memctl_wr_i)      memctl_o      <= memctl_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin : answer
    if (rst_i) begin
      op_ready_o  <= 1'b0;
      op_done_o   <= 1'b0;
      op_err_o    <= 1'b0;
      op_rdata_o  <= 32'h0;
      op_cycles_o <= 8'h0;
      op_reads_o  <= 3'h0;
      op_writes_o <= 3'h0;
      op_stall_o  <= 2'h0;
    end else if (clk_en_i) begin
      op_ready_o <= next_state == ST_IDLE;
      op_done_o  <= next_state == ST_DONE;
      if (next_state == ST_DONE) begin
        op_err_o    <= bus_err_i && bus_busy_state;
        op_rdata_o  <= next_acc;
        op_cycles_o <= take ? t_cycles : q_cycles + 8'(stall_cnt);
        op_reads_o  <= take ? t_reads : q_reads;
        op_writes_o <= take ? t_writes : q_writes;
        op_stall_o  <= take ? 2'h0 : stall_cnt;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin : core_state
    if (rst_i) begin
      halted_o  <= 1'b0;
      running_o <= 1'b0;
    end else if (clk_en_i) begin
      halted_o  <= next_state == ST_HALT;
      running_o <= next_state inside {ST_IDLE, ST_STALL, ST_READ,
                                      ST_WRITE, ST_DONE};
    end
  end

endmodule // crft_core

// ==== crft_cfg.svh ====
`ifndef CRFT_CFG_SVH
`define CRFT_CFG_SVH
// Summary of operation
// - a fault during exception processing for a fault halts the core at once.
// - the double-fault halt lasts until reset; nothing else leaves it.
// - reset outranks every exception and aborts work in progress for good.
// - reset sets supervisor, clears trace and master, sets priority mask to 7.
// - together with the status word, reset clears the vector base to zero.
// - reset disables the control of cache and local memory.
// - after reset, read longword 0 into stack pointer, 4 into program counter.
// - after the first fetch, execution starts at the loaded program counter.
// - access or address error before the first instruction ends in the halt.
// - a plain store keeps store resources busy two cycles; next store stalls.
// - a multi-register move neither causes nor suffers the store stall.
// - words need even addresses, longs addresses divisible by four.
// - misaligned operands split into byte/byte, byte/word/byte or word/word.
// - odd long costs 3(2/0) read, 2(0/2) write; others 2(1/0), 1(0/1).
// - cycle counts include all fetches, writes, internal cycles; rmw is (1/1).
// - program-counter-relative modes cost the same as address-register ones.

// status word layout and reset value
`define CRFT_SW_T_BIT      15
`define CRFT_SW_S_BIT      13
`define CRFT_SW_M_BIT      12
`define CRFT_SW_IPL_HI     10
`define CRFT_SW_IPL_LO     8
`define CRFT_SW_RESET      16'h2700
`define CRFT_VBR_RESET     32'h0000_0000
`define CRFT_MEMCTL_RESET  2'h0

// reset vector fetch addresses
`define CRFT_SP_VEC_ADDR   32'h0000_0000
`define CRFT_PC_VEC_ADDR   32'h0000_0004

// store resource busy window, cycles
`define CRFT_STORE_BUSY    2

// move timing, cycles
`define CRFT_CYC_REG       4'h1
`define CRFT_CYC_MEM_BW    4'h3
`define CRFT_CYC_MEM_L     4'h2
`define CRFT_CYC_IDX       4'h1

// misaligned extra cycles and extra references
`define CRFT_MIS_RD_ODDL   4'h3
`define CRFT_MIS_RD        4'h2
`define CRFT_MIS_WR_ODDL   4'h2
`define CRFT_MIS_WR        4'h1
`define CRFT_MIS_REF_ODDL  2'h2
`define CRFT_MIS_REF       2'h1

`endif

// ==== crft_pkg.sv ====
package crft_pkg;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crft_size_e;

  typedef enum logic [3:0] {
    EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_D16, EA_D8X,
    EA_ABSW, EA_ABSL, EA_PC_D16, EA_PC_D8X, EA_IMM
  } crft_ea_e;

  typedef enum logic [3:0] {
    ST_RST_SP, ST_RST_PC, ST_FETCH, ST_IDLE, ST_STALL,
    ST_READ, ST_WRITE, ST_DONE, ST_HALT
  } crft_state_e;

  function automatic logic ea_is_mem(crft_ea_e m);
    return !(m inside {EA_DREG, EA_AREG, EA_IMM});
  endfunction

  // pc-relative indexed folds onto the address-register form
  function automatic logic ea_is_idx(crft_ea_e m);
    return m inside {EA_D8X, EA_PC_D8X};
  endfunction

  function automatic logic is_misaligned(logic [1:0] lo, crft_size_e sz);
    return (sz == SZ_WORD && lo[0]) || (sz == SZ_LONG && lo != 2'h0);
  endfunction

  function automatic logic is_odd_long(logic [1:0] lo, crft_size_e sz);
    return sz == SZ_LONG && lo[0];
  endfunction

  function automatic logic [2:0] size_bytes(crft_size_e sz);
    case (sz)
      SZ_BYTE: return 3'h1;
      SZ_WORD: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction

  function automatic logic [31:0] size_mask(crft_size_e sz);
    case (sz)
      SZ_BYTE: return 32'h0000_00ff;
      SZ_WORD: return 32'h0000_ffff;
      default: return 32'hffff_ffff;
    endcase
  endfunction

endpackage

// ==== crft_split.sv ====
`timescale 1ns/10ps
`include "crft_cfg.svh"

module crft_split
  import crft_pkg::*;
(
  // operand
  input  wire logic [31:0] addr_i,
  input  crft_size_e       size_i,
  input  wire logic [1:0]  idx_i,
  // aligned piece
  output logic [31:0]      piece_addr_o,
  output crft_size_e       piece_size_o,
  output logic [1:0]       piece_off_o,
  output logic             piece_last_o
);

  always_comb begin
    piece_size_o = size_i;
    piece_off_o  = 2'h0;
    piece_last_o = 1'b1;
    if (!is_misaligned(addr_i[1:0], size_i)) begin
      piece_size_o = size_i;
    end else if (size_i == SZ_WORD) begin
      piece_size_o = SZ_BYTE;
      piece_off_o  = idx_i;
      piece_last_o = idx_i == 2'h1;
    end else if (is_odd_long(addr_i[1:0], size_i)) begin
      piece_size_o = (idx_i == 2'h1) ? SZ_WORD : SZ_BYTE;
      piece_off_o  = (idx_i == 2'h2) ? 2'h3 : idx_i;
      piece_last_o = idx_i == 2'h2;
    end else begin
      piece_size_o = SZ_WORD;
      piece_off_o  = {idx_i[0], 1'b0};
      piece_last_o = idx_i == 2'h1;
    end
  end

  assign piece_addr_o = addr_i + {30'h0, piece_off_o};

endmodule // crft_split

// ==== crft_timing.sv ====
`timescale 1ns/10ps
`include "crft_cfg.svh"

module crft_timing
  import crft_pkg::*;
(
  // operation
  input  crft_ea_e         src_ea_i,
  input  crft_ea_e         dst_ea_i,
  input  crft_size_e       size_i,
  input  wire logic        rmw_i,
  input  wire logic [1:0]  rd_lo_i,
  input  wire logic [1:0]  wr_lo_i,
  // modelled cost
  output logic [7:0]       cycles_o,
  output logic [2:0]       reads_o,
  output logic [2:0]       writes_o
);

  logic       rd;
  logic       wr;
  logic       idx;
  logic [3:0] base;
  logic [3:0] rd_x;
  logic [3:0] wr_x;
  logic [1:0] rd_n;
  logic [1:0] wr_n;

  always_comb begin
    rd   = ea_is_mem(src_ea_i) || rmw_i;
    wr   = ea_is_mem(dst_ea_i) || rmw_i;
    idx  = ea_is_idx(src_ea_i) || ea_is_idx(dst_ea_i);
    base = `CRFT_CYC_REG;
    if (rd || (src_ea_i == EA_IMM && wr)) begin
      base = (size_i == SZ_LONG) ? `CRFT_CYC_MEM_L : `CRFT_CYC_MEM_BW;
    end
    rd_x = 4'h0;
    rd_n = 2'h0;
    wr_x = 4'h0;
    wr_n = 2'h0;
    if (rd && is_misaligned(rd_lo_i, size_i)) begin
      rd_x = is_odd_long(rd_lo_i, size_i) ? `CRFT_MIS_RD_ODDL : `CRFT_MIS_RD;
      rd_n = is_odd_long(rd_lo_i, size_i) ? `CRFT_MIS_REF_ODDL : `CRFT_MIS_REF;
    end
    if (wr && is_misaligned(wr_lo_i, size_i)) begin
      wr_x = is_odd_long(wr_lo_i, size_i) ? `CRFT_MIS_WR_ODDL : `CRFT_MIS_WR;
      wr_n = is_odd_long(wr_lo_i, size_i) ? `CRFT_MIS_REF_ODDL : `CRFT_MIS_REF;
    end
    cycles_o = 8'(base) + 8'(idx) + 8'(rd_x) + 8'(wr_x);
    reads_o  = 3'(rd) + 3'(rd_n);
    writes_o = 3'(wr) + 3'(wr_n);
  end

endmodule // crft_timing

// ==== crft_core_asserts.sv ====
`timescale 1ns/10ps
module crft_core_asserts
  import crft_pkg::*;
(
  // clock, reset, faults
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        clk_en_i,
  input wire logic        fault_i,
  input wire logic        exc_active_i,
  // op answer, bus
  input wire logic        op_ready_o,
  input wire logic        op_done_o,
  input wire logic [1:0]  op_stall_o,
  input wire logic        bus_req_o,
  input wire logic [31:0] bus_addr_o,
  input crft_size_e       bus_size_o,
  input wire logic        bus_ack_i,
  input wire logic [31:0] bus_rdata_i,
  // core state
  input wire logic        halted_o,
  input wire logic        running_o,
  input wire logic [15:0] status_word_o,
  input wire logic [31:0] vector_base_o,
  input wire logic [1:0]  memctl_o,
  input wire logic [31:0] prog_ctr_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_fault_halt: assert property (
    fault_i && exc_active_i && clk_en_i |-> ##[0:2] halted_o)
    else $error("fault in exception did not halt");
  chk_halt_quiet: assert property (
    halted_o |-> !op_ready_o && !running_o)
    else $error("halted core still accepts work");
  chk_halt_sticky: assert property (
    halted_o |=> halted_o)
    else $error("halt left without reset");
  chk_reset_regs: assert property (
    $past(rst_i) |-> status_word_o == 16'h2700 &&
      vector_base_o == 32'h0 && memctl_o == 2'h0)
    else $error("reset values wrong");
  chk_reset_fetch: assert property (
    $past(rst_i) |-> ##[0:1] bus_req_o && bus_addr_o == 32'h0 &&
      bus_size_o == SZ_LONG)
    else $error("no stack pointer read after reset");
  chk_pc_fetch: assert property (
    !running_o && !halted_o && bus_req_o && bus_ack_i &&
      bus_addr_o == 32'h0 |=> bus_req_o && bus_addr_o == 32'h4)
    else $error("program counter read missing");
  chk_pc_load: assert property (
    !running_o && bus_req_o && bus_ack_i && bus_addr_o == 32'h4 &&
      !bus_rdata_i[0] |=> prog_ctr_o == $past(bus_rdata_i))
    else $error("program counter not loaded");
  chk_stall_bound: assert property (
    op_done_o |-> op_stall_o <= 2'h2)
    else $error("store stall above two");
  chk_piece_align: assert property (
    bus_req_o |-> !(bus_size_o == SZ_LONG && bus_addr_o[1:0] != 2'h0)
      && !(bus_size_o == SZ_WORD && bus_addr_o[0]))
    else $error("misaligned bus piece");
endmodule // crft_core_asserts
bind crft_core crft_core_asserts u_chk (.*);

// ==== crft_mem_model.sv ====
`timescale 1ns/10ps
module crft_mem_model
  import crft_pkg::*;
(
  // clock, reset, scenario control
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  wait_i,
  input  wire logic        err_en_i,
  // internal core bus
  input  wire logic        bus_req_i,
  input  crft_size_e       bus_size_i,
  input  wire logic [31:0] bus_addr_i,
  output logic             bus_ack_o,
  output logic             bus_err_o,
  output logic [31:0]      bus_rdata_o
);
  logic [1:0] cnt;
  logic [7:0] b;
  // byte at a holds a+0x11, so any span reads as a counting pattern
  assign b = bus_addr_i[7:0];
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 2'h0;
      bus_ack_o <= 1'b0;
      bus_err_o <= 1'b0;
      bus_rdata_o <= 32'h0;
    end else begin
      bus_ack_o <= 1'b0;
      bus_err_o <= 1'b0;
      bus_rdata_o <= ~bus_rdata_o;
      if (bus_req_i && !bus_ack_o && !bus_err_o) begin
        cnt <= cnt + 2'h1;
        if (cnt == wait_i) begin
          cnt <= 2'h0;
          bus_ack_o <= !err_en_i;
          bus_err_o <= err_en_i;
          case (bus_size_i)
            SZ_BYTE: bus_rdata_o <= {24'h0, b + 8'h11};
            SZ_WORD: bus_rdata_o <= {16'h0, b + 8'h11, b + 8'h12};
            default: bus_rdata_o <= {b + 8'h11, b + 8'h12, b + 8'h13,
                                     b + 8'h14};
          endcase
        end
      end
    end
  end
endmodule // crft_mem_model

// ==== crft_core_test.sv ====
`timescale 1ns/10ps
module crft_core_test;
  import crft_pkg::*;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1, fault_i = 1'b0;
  logic exc_active_i = 1'b0, status_word_wr_i = 1'b0, memctl_wr_i = 1'b0;
  logic vector_base_wr_i = 1'b0, op_valid_i = 1'b0, op_rmw_i = 1'b0;
  logic op_multi_move_i = 1'b0, merr = 1'b0;
  logic [1:0] memctl_i = 2'h0, mwait = 2'h0, op_stall_o, memctl_o;
  logic [15:0] status_word_i = 16'h0;
  logic [31:0] vector_base_i = 32'h0, op_wdata_i = 32'h5a5a_a5a5;
  logic [31:0] op_src_addr_i = 32'h0, op_dst_addr_i = 32'h0;
  crft_ea_e op_src_ea_i = EA_DREG, op_dst_ea_i = EA_DREG;
  crft_size_e op_size_i = SZ_BYTE, bus_size_o;
  logic op_ready_o, op_done_o, op_err_o, bus_req_o, bus_write_o;
  logic bus_ack_i, bus_err_i, halted_o, running_o;
  logic [2:0] op_reads_o, op_writes_o;
  logic [7:0] op_cycles_o;
  logic [15:0] status_word_o;
  logic [31:0] op_rdata_o, bus_addr_o, bus_wdata_o, bus_rdata_i;
  logic [31:0] vector_base_o, stack_ptr_o, prog_ctr_o, wlast;
  int fails = 0, checks_done = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  always @(negedge ref_clk_i)
    if (bus_req_o && bus_write_o && bus_ack_i) wlast <= bus_wdata_o;
  crft_core uut (.*);
  crft_mem_model u_mem (.ref_clk_i, .rst_i, .wait_i(mwait),
    .err_en_i(merr), .bus_req_i(bus_req_o), .bus_size_i(bus_size_o),
    .bus_addr_i(bus_addr_o), .bus_ack_o(bus_ack_i),
    .bus_err_o(bus_err_i), .bus_rdata_o(bus_rdata_i));
  //////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // 0 ready, 1 done, 2 boot ended
  task await(input int k);
    for (int n = 0; n < 200; n++) begin
      if ((k == 0 && op_ready_o === 1'b1) || (k == 1 && op_done_o === 1'b1)
          || (k == 2 && (running_o | halted_o) === 1'b1)) return;
      @(negedge ref_clk_i);
    end
    fails++;
    print_verdict();
  endtask
  task boot(input logic e);
    rst_i = 1'b1;
    merr = e;
    repeat (6) @(negedge ref_clk_i);
    chk("status_word", 32'(status_word_o), 32'h2700);
    chk("vector_base", vector_base_o, 32'h0);
    chk("memctl", 32'(memctl_o), 32'h0);
    rst_i = 1'b0;
    await(2);
  endtask
  task op(input crft_ea_e s, d, input crft_size_e z, input logic m, r,
          input logic [31:0] sa, da, input logic [7:0] c,
          input logic [2:0] nr, nw, input logic [1:0] st);
    await(0);
    op_src_ea_i = s;
    op_dst_ea_i = d;
    op_size_i = z;
    {op_multi_move_i, op_rmw_i, op_src_addr_i, op_dst_addr_i} = {m, r, sa, da};
    op_valid_i = 1'b1;
    @(negedge ref_clk_i);
    op_valid_i = 1'b0;
    await(1);
    chk("op_stall", 32'(op_stall_o), 32'(st));
    chk("op_cycles", 32'(op_cycles_o), 32'(c) + 32'(st));
    chk("op_reads", 32'(op_reads_o), 32'(nr));
    chk("op_writes", 32'(op_writes_o), 32'(nw));
    chk("op_err", 32'(op_err_o), 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    boot(1'b1);
    chk("halted", 32'(halted_o), 32'h1);
    boot(1'b0);
    chk("stack_ptr", stack_ptr_o, 32'h1112_1314);
    chk("prog_ctr", prog_ctr_o, 32'h1516_1718);
    op(EA_DREG, EA_DREG, SZ_WORD, 0, 0, 0, 0, 1, 0, 0, 0);
    op(EA_IND, EA_DREG, SZ_WORD, 0, 0, 32'h200, 0, 3, 1, 0, 0);
    chk("op_rdata", op_rdata_o, 32'h1112);
    op(EA_IND, EA_DREG, SZ_LONG, 0, 0, 32'h200, 0, 2, 1, 0, 0);
    op(EA_PC_D16, EA_DREG, SZ_LONG, 0, 0, 32'h204, 0, 2, 1, 0, 0);
    op(EA_PC_D8X, EA_DREG, SZ_BYTE, 0, 0, 32'h205, 0, 4, 1, 0, 0);
    mwait = 2'h2;
    op(EA_IND, EA_DREG, SZ_LONG, 0, 0, 32'h201, 0, 5, 3, 0, 0);
    chk("op_rdata", op_rdata_o, 32'h1213_1415);
    op(EA_IND, EA_DREG, SZ_LONG, 0, 0, 32'h202, 0, 4, 2, 0, 0);
    chk("op_rdata", op_rdata_o, 32'h1314_1516);
    op(EA_IND, EA_DREG, SZ_WORD, 0, 0, 32'h203, 0, 5, 2, 0, 0);
    chk("op_rdata", op_rdata_o, 32'h1415);
    mwait = 2'h0;
    op(EA_DREG, EA_IND, SZ_LONG, 0, 0, 0, 32'h301, 3, 0, 3, 0);
    chk("bus_wdata", wlast, 32'h0000_00a5);
    op(EA_DREG, EA_IND, SZ_WORD, 0, 0, 0, 32'h300, 1, 0, 1, 1);
    op(EA_DREG, EA_IND, SZ_LONG, 1, 0, 0, 32'h304, 1, 0, 1, 0);
    op(EA_DREG, EA_IND, SZ_LONG, 0, 0, 0, 32'h308, 1, 0, 1, 0);
    op(EA_DREG, EA_IND, SZ_WORD, 0, 0, 0, 32'h315, 2, 0, 2, 1);
    op(EA_DREG, EA_IND, SZ_LONG, 0, 0, 0, 32'h31a, 2, 0, 2, 1);
    op(EA_IND, EA_IND, SZ_LONG, 0, 0, 32'h200, 32'h30c, 2, 1, 1, 1);
    chk("bus_wdata", wlast, 32'h1112_1314);
    op(EA_DREG, EA_IND, SZ_LONG, 0, 1, 0, 32'h310, 2, 1, 1, 1);
    {status_word_i, vector_base_i, memctl_i} = {16'h0, 32'hffff_fff0, 2'h3};
    {status_word_wr_i, vector_base_wr_i, memctl_wr_i} = 3'h7;
    @(negedge ref_clk_i);
    {status_word_wr_i, vector_base_wr_i, memctl_wr_i} = 3'h0;
    mwait = 2'h3;
    op_valid_i = 1'b1;
    @(negedge ref_clk_i);
    op_valid_i = 1'b0;
    chk("vector_base", vector_base_o, 32'hffff_fff0);
    boot(1'b0); // aborts the stalled read-modify-write before its slow read
    chk("op_ready", 32'(op_ready_o), 32'h1);
    op(EA_DREG, EA_DREG, SZ_WORD, 0, 0, 0, 0, 1, 0, 0, 0);
    {fault_i, exc_active_i} = 2'h3;
    @(negedge ref_clk_i);
    {fault_i, exc_active_i} = 2'h0;
    repeat (3) @(negedge ref_clk_i);
    chk("halted", 32'(halted_o), 32'h1);
    repeat (20) @(negedge ref_clk_i);
    chk("halted", 32'(halted_o), 32'h1);
    chk("op_ready", 32'(op_ready_o), 32'h0);
    boot(1'b0);
    chk("halted", 32'(halted_o), 32'h0);
    print_verdict();
  end
endmodule // crft_core_test
